// ---- hw/lcdtp_port.sv ----
/*
 lcdtp_port: display timing and pixel pin mapping stage for a TFT or smart panel,
 with an AHB-Lite register slave. Assumes the pixel source runs on ref_clk and
 presents the next pixel whenever pix_take pulses; the panel samples the pins.
*/
// Behaviour
// [RL1] 16-bit rgb: blue 0-4 on pins 0-4, green 5-10, red 11-15.
// [RL2] 18-bit rgb: blue 0-5, green 6-11, red 12-17.
// [RL3] 24-bit rgb: blue 0-7, green 8-15, red from pin 16 up.
// [RL4] 8-bit ycrcb: luma and chroma alternate on pins 0-7, upper pins idle.
// [RL5] 16-bit ycrcb: chroma on pins 0-7, luma on pins 8-15.
// [RL6] 20-bit ycrcb: chroma on pins 0-9, luma on pins 10-19.
// [RL7] smart display: word bit n drives pin n, pins 0-15.
// [RL8] at most three contiguous, non-overlapping bit groups mapped independently.
// [RL9] component bit 0 is its lsb, higher bits in ascending order.
// [RL10] controls derive from the local start point via offset, up, down.
// [RL11] control edges land on whole interface clock periods only.
// [RL12] pixel data stays fixed to the start point; only controls shift.
// [RL13] panel clock runs continuously when active; panel samples falling edge.
// [RL14] horizontal sync once per line starts a new line.
// [RL15] vertical sync once per frame, always spanning a horizontal sync.
// [RL16] data valid enables data; deasserted means data invalid.
// [RL17] data valid may come from a timed or an untimed control pin.
// [RL18] horizontal sync position, width and active region are programmable.
// [RL19] vertical sync position, width and active lines are programmable.
// [RL20] inverted panel clock and active-low syncs and data valid supported.
// [RL21] control pin 2 carries horizontal sync, pin 3 vertical sync.
// [RL22] pixel and line counters compared to parameters produce control edges.
`timescale 1ns/100ps
`default_nettype none
module lcdtp_port
   import lcdtp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire lcdtp_pix_t pix_in,
   output logic pix_take,
   output logic [LCDTP_DAT_W-1:0] panel_data_pin,
   output logic panel_pixel_clock,
   output logic [3:0] ctl_pin
);
   logic ap_r, wr_r, hreadyout_r;
   logic [7:0] a_r;
   logic [31:0] hrdata_r;
   logic [9:0] ctrl_r;
   logic [7:0] div_r;
   logic [11:0] htot_r, vtot_r, ofs_r;
   lcdtp_win_t hs_r, vs_r, ha_r, va_r;
   lcdtp_grp_t g0_r, g1_r, g2_r;
   logic [7:0] div_cnt_r;
   logic [11:0] hcnt_r, vcnt_r;
   logic hs_act_r, vs_act_r, dv_act_r, yc_ph_r, pix_take_r, pclk_r;
   logic [LCDTP_DAT_W-1:0] data_r;
   logic [3:0] ctl_r;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   // bus decode
   wire acc = hsel && htrans[1] && hready;
   wire wr_en = ap_r && wr_r;
   wire sel_ctrl = (a_r == LCDTP_A_CTRL);
   wire sel_div = (a_r == LCDTP_A_DIV);
   wire sel_tot = (a_r == LCDTP_A_TOTAL);
   wire sel_hs = (a_r == LCDTP_A_HSYNC);
   wire sel_vs = (a_r == LCDTP_A_VSYNC);
   wire sel_ha = (a_r == LCDTP_A_HACT);
   wire sel_va = (a_r == LCDTP_A_VACT);
   wire sel_ofs = (a_r == LCDTP_A_OFS);
   wire sel_g01 = (a_r == LCDTP_A_GRP01);
   wire sel_g2 = (a_r == LCDTP_A_GRP2);
   wire sel_stat = (a_r == LCDTP_A_STAT);

   wire en = ctrl_r[LCDTP_C_EN];
   wire lcdtp_fmt_t fmt = lcdtp_fmt_t'(ctrl_r[LCDTP_C_FMT +: 3]);
   wire pclk_inv = ctrl_r[LCDTP_C_PCLK_INV];
   wire hs_low = ctrl_r[LCDTP_C_HS_LOW];
   wire vs_low = ctrl_r[LCDTP_C_VS_LOW];
   wire dv_low = ctrl_r[LCDTP_C_DV_LOW];
   wire dv_async = ctrl_r[LCDTP_C_DV_ASYNC];
   wire dv_lvl = ctrl_r[LCDTP_C_DV_LVL];

   // custom group mapping; a group that overlaps an earlier group still in use is dropped
   function automatic logic lcdtp_ovl(input lcdtp_grp_t a, input lcdtp_grp_t b);
      return ({1'b0, a.dst} < {1'b0, b.dst} + {1'b0, b.wid})
         && ({1'b0, b.dst} < {1'b0, a.dst} + {1'b0, a.wid});
   endfunction
   wire g0_ok = (g0_r.wid != 5'h00);
   wire g1_ok = (g1_r.wid != 5'h00) && !(g0_ok && lcdtp_ovl(g0_r, g1_r)); // RL8
   wire g2_ok = (g2_r.wid != 5'h00) && !(g0_ok && lcdtp_ovl(g0_r, g2_r))
      && !(g1_ok && lcdtp_ovl(g1_r, g2_r)); // RL8
   wire [2:0] grp_bad = {(g2_r.wid != 5'h00) && !g2_ok, (g1_r.wid != 5'h00) && !g1_ok, 1'b0};

   logic [LCDTP_DAT_W-1:0] cust;
   always_comb begin
      int s;
      lcdtp_grp_t g;
      logic ok;
      s = 0;
      g = g0_r;
      ok = 1'b0;
      cust = '0;
      for (int k = 0; k < 3; k++) begin
         g = (k == 0) ? g0_r : (k == 1) ? g1_r : g2_r;
         ok = (k == 0) ? g0_ok : (k == 1) ? g1_ok : g2_ok;
         for (int d = 0; d < LCDTP_DAT_W; d++) begin
            s = int'(g.src) + d - int'(g.dst);
            // group bit 0 lands on its lowest pin, ascending upward
            if (ok && d >= int'(g.dst) && d < int'(g.dst) + int'(g.wid) && s < LCDTP_PIX_W) begin
               cust[d] = pix_in[s]; // RL8 RL9
            end
         end
      end
   end

   // fixed format mapping; component lsb always on the lowest pin
   function automatic logic [LCDTP_DAT_W-1:0] lcdtp_map(input lcdtp_fmt_t f,
      input lcdtp_pix_t p, input logic ph, input logic [LCDTP_DAT_W-1:0] c);
      case (f)
         LCDTP_RGB16: return {8'h00, p.c2[4:0], p.c1[5:0], p.c0[4:0]}; // RL1 RL9
         LCDTP_RGB18: return {6'h00, p.c2[5:0], p.c1[5:0], p.c0[5:0]}; // RL2
         LCDTP_RGB24: return {p.c2[7:0], p.c1[7:0], p.c0[7:0]}; // RL3
         LCDTP_YC8: return {16'h0000, ph ? p.c0[7:0] : p.c1[7:0]}; // RL4
         LCDTP_YC16: return {8'h00, p.c1[7:0], p.c0[7:0]}; // RL5
         LCDTP_YC20: return {4'h0, p.c1, p.c0}; // RL6
         LCDTP_SMART: return {8'h00, p[15:0]}; // RL7
         LCDTP_CUSTOM: return c;
         default: return '0;
      endcase
   endfunction

   // interface clock divider: one enable per period, panel clock high in first half
   wire [7:0] div_eff = (div_r < 8'h02) ? 8'h02 : div_r;
   wire di_ce = en && (div_cnt_r == div_eff - 8'h01);
   wire [7:0] div_cnt_nxt = (!en || di_ce) ? 8'h00 : div_cnt_r + 8'h01;
   wire pclk_nxt = (en && (div_cnt_nxt < (div_eff >> 1))) ^ pclk_inv; // RL13 RL20

   // pixel and line counters; hcnt 0 is the local start point
   wire hwrap = (hcnt_r >= htot_r - 12'h001);
   wire vwrap = (vcnt_r >= vtot_r - 12'h001);
   wire [11:0] hcnt_nxt = hwrap ? 12'h000 : hcnt_r + 12'h001; // RL22
   wire [11:0] vcnt_nxt = vwrap ? 12'h000 : vcnt_r + 12'h001; // RL22

   // hsync and data valid see the counter moved by the offset; vsync (set at hcnt 0) and the data window do not
   wire [11:0] hctl = hcnt_r - ofs_r; // RL10 RL12
   wire [11:0] vs_dn = (vs_r.dn <= vs_r.up) ? vs_r.up + 12'h001 : vs_r.dn;
   wire hs_win = (hctl >= hs_r.up) && (hctl < hs_r.dn); // RL14 RL18
   wire vs_win = (vcnt_r >= vs_r.up) && (vcnt_r < vs_dn); // RL19
   wire va_win = (vcnt_r >= va_r.up) && (vcnt_r < va_r.dn); // RL19
   wire dv_win = (hctl >= ha_r.up) && (hctl < ha_r.dn) && va_win; // RL16 RL18
   wire d_win = (hcnt_r >= ha_r.up) && (hcnt_r < ha_r.dn) && va_win; // RL12
   wire take = d_win && (fmt != LCDTP_YC8 || yc_ph_r);

   // vertical sync only moves at a line start, so it always holds whole lines
   wire vs_nxt = !en ? 1'b0 : (di_ce && hcnt_r == 12'h000) ? vs_win : vs_act_r; // RL15
   wire hs_nxt = !en ? 1'b0 : di_ce ? hs_win : hs_act_r; // RL11 RL14
   wire dv_nxt = !en ? 1'b0 : di_ce ? dv_win : dv_act_r; // RL11 RL16
   wire dv_pin = dv_async ? dv_lvl : dv_nxt; // RL17

   wire [31:0] rd_mux =
      sel_ctrl ? {22'h0, ctrl_r} :
      sel_div ? {24'h0, div_r} :
      sel_tot ? {4'h0, vtot_r, 4'h0, htot_r} :
      sel_hs ? {4'h0, hs_r.dn, 4'h0, hs_r.up} :
      sel_vs ? {4'h0, vs_r.dn, 4'h0, vs_r.up} :
      sel_ha ? {4'h0, ha_r.dn, 4'h0, ha_r.up} :
      sel_va ? {4'h0, va_r.dn, 4'h0, va_r.up} :
      sel_ofs ? {20'h0, ofs_r} :
      sel_g01 ? {1'b0, g1_r, 1'b0, g0_r} :
      sel_g2 ? {17'h0, g2_r} :
      sel_stat ? {4'h0, vcnt_r, 8'h00, 1'b0, grp_bad, 1'b0, dv_act_r, hs_act_r, vs_act_r} :
      32'h0;

   // one wait state: read data come from a flop in the second data cycle
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ap_r <= 1'b0;
         wr_r <= 1'b0;
         a_r <= 8'h00;
         hreadyout_r <= 1'b1;
         hrdata_r <= 32'h0;
      end else if (acc) begin
         ap_r <= 1'b1;
         wr_r <= hwrite;
         a_r <= {haddr[7:2], 2'b00};
         hreadyout_r <= 1'b0;
      end else if (ap_r) begin
         ap_r <= 1'b0;
         hreadyout_r <= 1'b1;
         hrdata_r <= wr_r ? 32'h0 : rd_mux;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl_r <= LCDTP_CTRL_RST;
         div_r <= LCDTP_DIV_RST;
         htot_r <= LCDTP_HTOT_RST;
         vtot_r <= LCDTP_VTOT_RST;
         ofs_r <= LCDTP_OFS_RST;
      end else if (wr_en) begin
         if (sel_ctrl) ctrl_r <= hwdata[9:0];
         if (sel_div) div_r <= hwdata[7:0];
         if (sel_tot) htot_r <= hwdata[LCDTP_LO_POS +: 12];
         if (sel_tot) vtot_r <= hwdata[LCDTP_HI_POS +: 12];
         if (sel_ofs) ofs_r <= hwdata[11:0];
      end
   end

   wire lcdtp_win_t w_in = '{dn: hwdata[LCDTP_HI_POS +: 12], up: hwdata[LCDTP_LO_POS +: 12]};
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         hs_r <= LCDTP_HS_RST;
         vs_r <= LCDTP_VS_RST;
         ha_r <= LCDTP_HA_RST;
         va_r <= LCDTP_VA_RST;
         g0_r <= LCDTP_GRP_RST;
         g1_r <= LCDTP_GRP_RST;
         g2_r <= LCDTP_GRP_RST;
      end else if (wr_en) begin
         if (sel_hs) hs_r <= w_in;
         if (sel_vs) vs_r <= w_in;
         if (sel_ha) ha_r <= w_in;
         if (sel_va) va_r <= w_in;
         if (sel_g01) g0_r <= hwdata[14:0];
         if (sel_g01) g1_r <= hwdata[LCDTP_GRP1_POS +: 15];
         if (sel_g2) g2_r <= hwdata[14:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         div_cnt_r <= 8'h00;
         hcnt_r <= 12'h000;
         vcnt_r <= 12'h000;
      end else begin
         div_cnt_r <= div_cnt_nxt;
         if (!en) begin
            hcnt_r <= 12'h000;
            vcnt_r <= 12'h000;
         end else if (di_ce) begin
            hcnt_r <= hcnt_nxt;
            if (hwrap) vcnt_r <= vcnt_nxt;
         end
      end
   end

   // data change only on an interface clock enable, half a period before the sample edge
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         hs_act_r <= 1'b0;
         vs_act_r <= 1'b0;
         dv_act_r <= 1'b0;
         yc_ph_r <= 1'b0;
         pix_take_r <= 1'b0;
         data_r <= '0;
      end else begin
         hs_act_r <= hs_nxt;
         vs_act_r <= vs_nxt;
         dv_act_r <= dv_nxt;
         pix_take_r <= di_ce && take;
         if (!en) begin
            yc_ph_r <= 1'b0;
            data_r <= '0;
         end else if (di_ce) begin
            yc_ph_r <= d_win && !yc_ph_r; // RL4
            data_r <= d_win ? lcdtp_map(fmt, pix_in, yc_ph_r, cust) : '0; // RL12
         end
      end
   end

   // pin 0 is unused and rests low; pin 1 carries data valid
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctl_r <= 4'h0;
         pclk_r <= 1'b0;
      end else begin
         ctl_r <= {vs_nxt ^ vs_low, hs_nxt ^ hs_low, dv_pin ^ dv_low, 1'b0}; // RL20 RL21
         pclk_r <= pclk_nxt; // RL13
      end
   end

   assign hreadyout = hreadyout_r;
   assign hrdata = hrdata_r;
   assign hresp = 1'b0;
   assign pix_take = pix_take_r;
   assign panel_data_pin = data_r;
   assign panel_pixel_clock = pclk_r;
   assign ctl_pin = ctl_r;

   sequence s_rd_acc;
      hsel && htrans[1] && hready && !hwrite;
   endsequence
   sequence s_wait_ready;
      !hreadyout ##1 hreadyout;
   endsequence
   sequence s_en_held;
      en [*3];
   endsequence

   a_pclk_runs: assert property (s_en_held |-> ##[0:520] ($changed(panel_pixel_clock) || !en)) // RL13
      else $error("panel clock stopped while active");
   a_hs_quantised: assert property ($rose(hs_act_r) |-> $past(di_ce)) // RL11
      else $error("hsync edge off the interface clock");
   a_vs_line_start: assert property ($changed(vs_act_r) && en |-> $past(di_ce && hcnt_r == 12'h000)) // RL15
      else $error("vsync moved inside a line");
   a_dv_quantised: assert property ($changed(dv_act_r) && en |-> $past(di_ce)) // RL16
      else $error("data valid edge off the interface clock");
   a_data_fixed: assert property ($changed(panel_data_pin) |-> $past(di_ce || !en)) // RL12
      else $error("data moved off the start point grid");
   a_hs_idle_pol: assert property (!en ##1 !en |-> ctl_pin[2] == hs_low && ctl_pin[3] == vs_low) // RL20
      else $error("idle sync level ignores polarity");
   a_rgb16_map: assert property (pix_take && fmt == LCDTP_RGB16 && $stable(ctrl_r)
      |-> panel_data_pin[15:0] == {$past(pix_in.c2[4:0]), $past(pix_in.c1[5:0]),
      $past(pix_in.c0[4:0])}) // RL1
      else $error("rgb16 pin map wrong");
   a_rgb24_map: assert property (pix_take && fmt == LCDTP_RGB24 && $stable(ctrl_r)
      |-> panel_data_pin == {$past(pix_in.c2[7:0]), $past(pix_in.c1[7:0]),
      $past(pix_in.c0[7:0])}) // RL3
      else $error("rgb24 pin map wrong");
   a_yc16_map: assert property (pix_take && fmt == LCDTP_YC16 && $stable(ctrl_r)
      |-> panel_data_pin[15:0] == {$past(pix_in.c1[7:0]), $past(pix_in.c0[7:0])}) // RL5
      else $error("ycrcb16 pin map wrong");
   a_bus_wait: assert property (s_rd_acc |=> s_wait_ready)
      else $error("read answer timing wrong");

   // remaining fixed maps; data lag the pixel by one cycle, so pix_in is taken one back
   a_rgb18_map: assert property (pix_take && fmt == LCDTP_RGB18 && $stable(ctrl_r) // RL2
      |-> panel_data_pin == {6'h00, $past(pix_in.c2[5:0]), $past(pix_in.c1[5:0]),
      $past(pix_in.c0[5:0])})
      else $error("rgb18 pin map wrong");
   a_yc8_chroma: assert property (pix_take && fmt == LCDTP_YC8 && $stable(ctrl_r) // RL4
      |-> panel_data_pin == {16'h0000, $past(pix_in.c0[7:0])})
      else $error("ycrcb8 chroma period wrong");
   a_yc20_map: assert property (pix_take && fmt == LCDTP_YC20 && $stable(ctrl_r) // RL6
      |-> panel_data_pin == {4'h0, $past(pix_in.c1), $past(pix_in.c0)})
      else $error("ycrcb20 pin map wrong");
   a_smart_map: assert property (pix_take && fmt == LCDTP_SMART && $stable(ctrl_r) // RL7
      |-> panel_data_pin == {8'h00, $past(pix_in[15:0])})
      else $error("smart word map wrong");
   a_take_quantised: assert property (pix_take |-> $past(di_ce)) // RL11
      else $error("pixel taken off the interface clock");

   // pins must follow the internal state through their polarity bits
   a_hs_pin_pol: assert property (ctl_pin[2] == (hs_act_r ^ $past(hs_low))) // RL20 RL21
      else $error("hsync pin disagrees with state");
   a_vs_pin_pol: assert property (ctl_pin[3] == (vs_act_r ^ $past(vs_low))) // RL20 RL21
      else $error("vsync pin disagrees with state");
   a_dv_pin_timed: assert property (!$past(dv_async) // RL16
      |-> ctl_pin[1] == (dv_act_r ^ $past(dv_low)))
      else $error("data valid pin disagrees with state");
   a_dv_untimed: assert property ($past(dv_async) // RL17
      |-> ctl_pin[1] == ($past(dv_lvl) ^ $past(dv_low)))
      else $error("untimed data valid level wrong");

   // the counters, compared with the window and offset registers, decide where every timed control edge falls
   a_hcnt_wrap: assert property (en && di_ce && hwrap |=> hcnt_r == 12'h000) // RL22
      else $error("pixel counter did not wrap");
   a_hcnt_step: assert property (en && di_ce && !hwrap // RL22
      |=> hcnt_r == $past(hcnt_r) + 12'h001)
      else $error("pixel counter skipped");
   a_hcnt_hold: assert property (en && !di_ce |=> hcnt_r == $past(hcnt_r)) // RL11
      else $error("pixel counter moved between enables");
endmodule
`default_nettype wire

// ---- hw/lcdtp_pkg.sv ----
/*
 lcdtp_pkg: register map, field layout, reset values and carrier types of the
 panel timing port. Assumes a 32-bit AHB-Lite register bus, one word per register.
*/
package lcdtp_pkg;
   // word offsets (byte addresses) on the register bus
   localparam logic [7:0] LCDTP_A_CTRL = 8'h00;
   localparam logic [7:0] LCDTP_A_DIV = 8'h04;
   localparam logic [7:0] LCDTP_A_TOTAL = 8'h08;
   localparam logic [7:0] LCDTP_A_HSYNC = 8'h0c;
   localparam logic [7:0] LCDTP_A_VSYNC = 8'h10;
   localparam logic [7:0] LCDTP_A_HACT = 8'h14;
   localparam logic [7:0] LCDTP_A_VACT = 8'h18;
   localparam logic [7:0] LCDTP_A_OFS = 8'h1c;
   localparam logic [7:0] LCDTP_A_GRP01 = 8'h20;
   localparam logic [7:0] LCDTP_A_GRP2 = 8'h24;
   localparam logic [7:0] LCDTP_A_STAT = 8'h28;
   // control register bit positions
   localparam int LCDTP_C_EN = 0;
   localparam int LCDTP_C_FMT = 1;
   localparam int LCDTP_C_PCLK_INV = 4;
   localparam int LCDTP_C_HS_LOW = 5;
   localparam int LCDTP_C_VS_LOW = 6;
   localparam int LCDTP_C_DV_LOW = 7;
   localparam int LCDTP_C_DV_ASYNC = 8;
   localparam int LCDTP_C_DV_LVL = 9;
   // two 12-bit fields per word: low field and high field
   localparam int LCDTP_LO_POS = 0;
   localparam int LCDTP_HI_POS = 16;
   localparam int LCDTP_GRP1_POS = 16;
   localparam int LCDTP_STAT_GRP_POS = 4;
   localparam int LCDTP_CNT_W = 12;
   localparam int LCDTP_DAT_W = 24;
   localparam int LCDTP_PIX_W = 30;
   typedef enum logic [2:0] {
      LCDTP_RGB16, LCDTP_RGB18, LCDTP_RGB24, LCDTP_YC8, LCDTP_YC16, LCDTP_YC20,
      LCDTP_SMART, LCDTP_CUSTOM
   } lcdtp_fmt_t;
   // c0 = blue or chroma, c1 = green or luma, c2 = red; lsb of each in bit 0
   typedef struct packed {
      logic [9:0] c2;
      logic [9:0] c1;
      logic [9:0] c0;
   } lcdtp_pix_t;
   typedef struct packed {
      logic [11:0] dn;
      logic [11:0] up;
   } lcdtp_win_t;
   typedef struct packed {
      logic [4:0] wid;
      logic [4:0] dst;
      logic [4:0] src;
   } lcdtp_grp_t;
   // reset values
   localparam logic [9:0] LCDTP_CTRL_RST = 10'h000;
   localparam logic [7:0] LCDTP_DIV_RST = 8'h02;
   localparam logic [11:0] LCDTP_HTOT_RST = 12'h020;
   localparam logic [11:0] LCDTP_VTOT_RST = 12'h010;
   localparam lcdtp_win_t LCDTP_HS_RST = '{dn: 12'h002, up: 12'h000};
   localparam lcdtp_win_t LCDTP_VS_RST = '{dn: 12'h001, up: 12'h000};
   localparam lcdtp_win_t LCDTP_HA_RST = '{dn: 12'h01c, up: 12'h004};
   localparam lcdtp_win_t LCDTP_VA_RST = '{dn: 12'h00e, up: 12'h002};
   localparam logic [11:0] LCDTP_OFS_RST = 12'h000;
   localparam lcdtp_grp_t LCDTP_GRP_RST = '{wid: 5'h00, dst: 5'h00, src: 5'h00};
endpackage

// ---- testbench/lcdtp_panel_model.sv ----
/*
 lcdtp_panel_model: behavioural tft panel at the far side of the timing port.
 Assumes ref_clk oversamples the panel clock; reports line and frame counts.
*/
`timescale 1ns/100ps
`default_nettype none
module lcdtp_panel_model (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic panel_pixel_clock,
   input wire logic [23:0] panel_data_pin,
   input wire logic [3:0] ctl_pin,
   input wire logic m_inv,
   input wire logic [2:0] m_low,
   output logic fr_stb,
   output logic [7:0] cap_per,
   output logic [7:0] hs_w,
   output logic [7:0] d_pos,
   output logic [7:0] lines,
   output logic [7:0] vs_w,
   output logic [7:0] act_lines,
   output logic [7:0] dv_f,
   output logic [7:0] idle_nz,
   output logic [23:0] first_dat
);
   // polarity is normalised here so counts read the same for either setting
   wire logic pc = panel_pixel_clock ^ m_inv;
   wire logic dv = ctl_pin[1] ^ m_low[0];
   wire logic hs = ctl_pin[2] ^ m_low[1];
   wire logic vs = ctl_pin[3] ^ m_low[2];
   logic pc_q, hs_q, vs_q, seen, got;
   logic [7:0] per_c, pos, ln_c, vs_c, act_c, dvf_c, dv_l, hs_c;
   always @(posedge ref_clk) begin
      fr_stb <= 1'b0;
      pc_q <= pc;
      per_c = per_c + 1;
      if (rst) begin
         {per_c, pos, ln_c, vs_c, act_c, dvf_c, dv_l, hs_c} = '0;
         {hs_q, vs_q, seen, got} = '0;
         idle_nz <= '0;
      end else if (pc_q && !pc) begin
         cap_per <= per_c;
         per_c = 0;
         if (hs && !hs_q) begin
            hs_w <= hs_c;
            if (dv_l != 0) act_c++;
            dvf_c = dvf_c + dv_l;
            if (vs && !vs_q) begin
               {lines, vs_w, act_lines, dv_f} <= {ln_c, vs_c, act_c, dvf_c};
               fr_stb <= 1'b1;
               {ln_c, vs_c, act_c, dvf_c} = '0;
            end
            ln_c++;
            if (vs) vs_c++;
            vs_q = vs;
            {pos, hs_c, dv_l, seen, got} = '0;
         end
         hs_q = hs;
         if (hs) hs_c++;
         if (!seen && panel_data_pin != 0) begin
            d_pos <= pos;
            seen = 1'b1;
         end
         pos++;
         if (dv) begin
            if (!got) first_dat <= panel_data_pin;
            got = 1'b1;
            dv_l++;
         end else if (panel_data_pin != 0)
            idle_nz <= idle_nz + 1;
      end
   end
endmodule
`default_nettype wire

// ---- testbench/test_lcdtp_port.sv ----
/*
 test_lcdtp_port: self-checking bench for the panel timing port.
 Assumes the design package and lcdtp_panel_model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module test_lcdtp_port
   import lcdtp_pkg::*;
;
   localparam logic [7:0] RA[11] = '{LCDTP_A_CTRL, LCDTP_A_DIV, LCDTP_A_TOTAL, LCDTP_A_HSYNC,
      LCDTP_A_VSYNC, LCDTP_A_HACT, LCDTP_A_VACT, LCDTP_A_OFS, LCDTP_A_GRP01, LCDTP_A_GRP2, 8'h3c};
   localparam logic [31:0] RV[11] = '{32'h0, 32'h2, 32'h0010_0020, 32'h0002_0000, 32'h0001_0000,
      32'h001c_0004, 32'h000e_0002, 32'h0, 32'h0, 32'h0, 32'h0};
   // div 8 gives the 400 ns panel clock; a short line and frame keep the run brief
   localparam logic [7:0] WA[9] = '{LCDTP_A_DIV, LCDTP_A_TOTAL, LCDTP_A_HSYNC, LCDTP_A_VSYNC,
      LCDTP_A_HACT, LCDTP_A_VACT, LCDTP_A_GRP01, LCDTP_A_GRP2, LCDTP_A_CTRL};
   localparam logic [31:0] WV[9] = '{32'h8, 32'h0006_0010, 32'h0003_0001, 32'h0003_0001,
      32'h000c_0004, 32'h0005_0003, 32'h110a_1000, 32'h0000_2214, 32'h1};
   logic ref_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, m_inv = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, q;
   logic [1:0] htrans = '0;
   logic [2:0] hsize = 3'h2, m_low = '0;
   lcdtp_pix_t pix_in = '{c2: 10'h2b5, c1: 10'h1c3, c0: 10'h36a};
   wire logic hreadyout, hresp, pix_take, panel_pixel_clock, fr_stb;
   wire logic [31:0] hrdata;
   wire logic [23:0] panel_data_pin, first_dat;
   wire logic [3:0] ctl_pin;
   wire logic [7:0] cap_per, hs_w, d_pos, lines, vs_w, act_lines, dv_f, idle_nz;
   int fail_count = 0, n_tests = 0, cyc = 0, takes;

   lcdtp_port lcdtp_port_inst (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .pix_in, .pix_take,
      .panel_data_pin, .panel_pixel_clock, .ctl_pin);
   lcdtp_panel_model lcdtp_panel_model_inst (.ref_clk, .rst, .panel_pixel_clock,
      .panel_data_pin, .ctl_pin, .m_inv, .m_low, .fr_stb, .cap_per, .hs_w, .d_pos, .lines,
      .vs_w, .act_lines, .dv_f, .idle_nz, .first_dat);

   always #25 ref_clk = ~ref_clk;

   task close_out;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 40000) begin
         fail_count++;
         $display("BAD %0t run did not finish", $time);
         close_out;
      end
   end

   task chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         fail_count++;
         $display("BAD %0t seen %h expected %h", $time, s, e);
      end
   endtask

   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask

   // the first strobe may close a frame spoilt by reprogramming, so it is skipped
   task frames(output int n);
      n = 0;
      do @(posedge ref_clk); while (fr_stb !== 1'b1);
      do begin
         @(posedge ref_clk);
         if (pix_take === 1'b1) n++;
      end while (fr_stb !== 1'b1);
   endtask

   function automatic logic [23:0] expd(input int f);
      case (f)
         0: expd = {8'h0, pix_in.c2[4:0], pix_in.c1[5:0], pix_in.c0[4:0]};
         1: expd = {6'h0, pix_in.c2[5:0], pix_in.c1[5:0], pix_in.c0[5:0]};
         2: expd = {pix_in.c2[7:0], pix_in.c1[7:0], pix_in.c0[7:0]};
         3: expd = {16'h0, pix_in.c1[7:0]};
         4: expd = {8'h0, pix_in.c1[7:0], pix_in.c0[7:0]};
         5: expd = {4'h0, pix_in.c1[9:0], pix_in.c0[9:0]};
         6: expd = {8'h0, pix_in[15:0]};
         default: expd = {pix_in[27:20], 4'h0, pix_in[13:10], 4'h0, pix_in[3:0]};
      endcase
   endfunction

   task t_regs;
      bus(1'b1, 8'h3c, 32'hffff_ffff);
      for (int i = 0; i < 11; i++) begin
         bus(1'b0, RA[i], 32'h0);
         chk(q, RV[i]);
      end
      chk(hresp, 1'b0);
      for (int i = 0; i < 9; i++)
         bus(1'b1, WA[i], WV[i]);
      for (int i = 0; i < 9; i++) begin
         bus(1'b0, WA[i], 32'h0);
         chk(q, WV[i]);
      end
   endtask

   task t_frame(input logic [7:0] p);
      frames(takes);
      chk(lines, 8'd6);
      chk(hs_w, 8'd2);
      chk(vs_w, 8'd2);
      chk(act_lines, 8'd2);
      chk(dv_f, 8'd16);
      chk(cap_per, 8'd8);
      chk(d_pos, p);
      chk(takes, 16);
   endtask

   task t_fmt(input int f);
      bus(1'b1, LCDTP_A_CTRL, (f << LCDTP_C_FMT) | 1);
      frames(takes);
      chk(first_dat, expd(f));
      chk(takes, (f == 3) ? 8 : 16);
   endtask

   task t_overlap;
      bus(1'b1, LCDTP_A_GRP2, 32'h0000_2154);
      bus(1'b0, LCDTP_A_STAT, 32'h0);
      chk(q & 32'h70, 32'h40);
      frames(takes);
      chk(first_dat, expd(7) & 24'h00ffff);
   endtask

   task t_pol;
      bus(1'b1, LCDTP_A_CTRL, 32'hf1);
      m_inv <= 1'b1;
      m_low <= 3'h7;
      t_frame(8'd3);
      chk(act_lines, 8'd2);
   endtask

   // the untimed level has no completion signal, so a short settle is allowed
   task t_untimed;
      bus(1'b1, LCDTP_A_CTRL, 32'h301);
      m_inv <= 1'b0;
      m_low <= 3'h0;
      repeat (10) @(posedge ref_clk);
      chk(ctl_pin[1], 1'b1);
      chk(ctl_pin[0], 1'b0);
      bus(1'b1, LCDTP_A_CTRL, 32'h101);
      repeat (10) @(posedge ref_clk);
      chk(ctl_pin[1], 1'b0);
   endtask

   task t_ofs;
      bus(1'b1, LCDTP_A_CTRL, 32'h1);
      bus(1'b1, LCDTP_A_OFS, 32'h2);
      t_frame(8'd1);
      chk(hs_w, 8'd2);
   endtask

   initial begin
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      t_regs;
      t_frame(8'd3);
      for (int f = 0; f < 8; f++)
         t_fmt(f);
      chk(idle_nz, 32'h0);
      t_overlap;
      t_pol;
      t_untimed;
      t_ofs;
      close_out;
   end
endmodule
`default_nettype wire
